// File: core/flash_front_end_params.svh
// Constants for the flash command front end: offsets, fields, reset values and timing.
`ifndef FLASH_FRONT_END_PARAMS_SVH
`define FLASH_FRONT_END_PARAMS_SVH
`define OFS_CLOCK_RATIO     5'h02
`define OFS_USER_STATUS     5'h05
`define OFS_COMMAND         5'h06
`define OFS_LATENCY_SELECT  5'h07
`define OFS_CONTROL         5'h08
`define CMD_BLANK_CHECK     7'h05
`define CMD_PAGE_VERIFY     7'h06
`define CMD_PROGRAM         7'h20
`define CMD_PAGE_ERASE      7'h40
`define CMD_MASS_ERASE      7'h41
`define STAT_BUF_EMPTY_BIT  7
`define STAT_COMPLETE_BIT   6
`define STAT_PROT_VIOL_BIT  5
`define STAT_ACC_ERR_BIT    4
`define STAT_BLANK_BIT      2
`define CLKD_LOADED_BIT     7
`define CLKD_PRESCALE_BIT   6
`define CTRL_BUF_IE_BIT     7
`define CTRL_CMP_IE_BIT     6
`define LATENCY_FAST        2'b10
`define LATENCY_RESET       2'b10
`define PRESCALE_DIVIDE     8
`define PROG_TICKS          8'h1E
`define ERASE_TICKS         8'h80
`define VERIFY_CYCLES       16'h0040
`define PUMP_SETUP_TICKS    8'h04
`endif

// File: core/flash_front_end_pkg.sv
// Types shared by the flash command front end.
package flash_front_end_pkg;
  typedef enum logic [1:0] {EXEC_IDLE, EXEC_PUMP, EXEC_RUN} exec_state_t;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_ARRAY, SEQ_CMD} seq_state_t;
endpackage

// File: core/timebase_divider.sv
// Prescaler and programmable divider that make the program timebase tick.
`timescale 1ns/1ps
`default_nettype none
`include "flash_front_end_params.svh"
module timebase_divider #(
  parameter int RATIO_W = 6
) (
  // Clock and reset.
  input  wire logic               clk,
  input  wire logic               rstn,
  // Setting.
  input  wire logic               prescale_by_eight,
  input  wire logic [RATIO_W-1:0] ratio,
  input  wire logic               restart,
  // Timebase.
  output logic                    tick
);
  typedef struct packed {
    logic [2:0]         pre;
    logic [RATIO_W-1:0] div;
    logic               tick;
  } div_state_t;
  div_state_t s_r;
  div_state_t s_nxt;
  logic pre_done;
  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    pre_done = !prescale_by_eight || (s_r.pre == 3'(`PRESCALE_DIVIDE - 1)); // [R15]
    if (restart) begin
      s_nxt.pre = 3'h0;
      s_nxt.div = '0;
    end else begin
      s_nxt.pre = pre_done ? 3'h0 : s_r.pre + 3'h1;
      if (pre_done) begin
        if (s_r.div >= ratio) begin // [R15]
          s_nxt.div = '0;
          s_nxt.tick = 1'b1;
        end else begin
          s_nxt.div = s_r.div + 1'b1;
        end
      end
    end
  end
  always_ff @(posedge clk or negedge rstn) begin // [R9]
    if (!rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign tick = s_r.tick;
endmodule
`default_nettype wire

// File: core/flash_command_front_end.sv
// Command register, latency select, access checks, command queue and timebase of the flash.
// Behaviour
// [R1] Command bit 7 reads zero; six-zero read/write.
// [R2] Only five command codes are legal.
// [R3] Illegal command code sets access error.
// [R4] Latency field read-only fixed; upper bits zero.
// [R5] Latency 2'b10 gives one-cycle reads, else two.
// [R6] Array read needs request, range, read direction; the code checks request and read direction, with no range check.
// [R7] Array write latched; command decides its effect.
// [R8] Non-word array writes end in transfer error.
// [R9] Timebase derives only from the bus clock.
// [R10] Command, address, data form a two-stage queue.
// [R11] Same-row programs keep high voltage active.
// [R12] Empty and complete flags raise enabled interrupts.
// [R13] Software sets ratio before any command.
// [R14] Software sets prescale above 12.8 MHz.
// [R15] Timebase is clock, prescaled, over ratio plus one.
// [R16] Software picks ratio from 200 kHz quotient.
// [R17] Software keeps timebase at least 150 kHz.
// [R18] Software keeps timebase at most 200 kHz.
// [R19] Execution time scales with timebase period; the code counts the run phase of blank check and page verify in bus clocks, not ticks.
// [R20] Ratio write sets loaded flag; reset clears.
// [R21] No command executes before ratio loaded.
// [R22] Writing one to empty flag launches command.
// [R23] Launch clears complete flag same cycle.
// [R24] Access error blocks launch and new sequence.
// [R25] Launch without ratio sets access error.
`timescale 1ns/1ps
`default_nettype none
`include "flash_front_end_params.svh"
module flash_command_front_end #(
  parameter int          ADDR_W    = 19,
  parameter int          ROW_LSB   = 8,
  parameter logic [1:0]  LATENCY   = `LATENCY_RESET
) (
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              rstn,
  // Register port.
  input  wire logic              reg_sel,
  input  wire logic              reg_write,
  input  wire logic [4:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  output logic      [15:0]       reg_rdata,
  // Array bus port.
  input  wire logic              arr_req,
  input  wire logic              arr_write,
  input  wire logic [1:0]        arr_size,
  input  wire logic [ADDR_W-1:0] arr_addr,
  input  wire logic [31:0]       arr_wdata,
  output logic                   arr_ack,
  output logic                   arr_err,
  output logic                   arr_read_en,
  // Array engine.
  output logic                   engine_busy,
  output logic [6:0]             engine_cmd,
  output logic [ADDR_W-1:0]      engine_addr,
  output logic [31:0]            engine_data,
  output logic                   high_voltage,
  output logic                   timebase_tick,
  input  wire logic              engine_blank,
  // Interrupts.
  output logic                   buf_empty_irq,
  output logic                   complete_irq
);
  typedef struct packed {
    logic [6:0]                     cmd;
    logic [5:0]                     ratio;
    logic                           prescale;
    logic                           loaded;
    logic                           buf_empty;
    logic                           complete;
    logic                           acc_err;
    logic                           blank;
    logic                           buf_ie;
    logic                           cmp_ie;
    flash_front_end_pkg::seq_state_t seq;
    logic                           pend_v;
    logic [6:0]                     pend_cmd;
    logic [ADDR_W-1:0]              pend_addr;
    logic [31:0]                    pend_data;
    logic [ADDR_W-1:0]              buf_addr;
    logic [31:0]                    buf_data;
    flash_front_end_pkg::exec_state_t ex;
    logic [6:0]                     ex_cmd;
    logic [ADDR_W-1:0]              ex_addr;
    logic [31:0]                    ex_data;
    logic [15:0]                    ex_cnt;
    logic                           hv;
    logic                           busy;
    logic [15:0]                    rdata;
    logic                           ack;
    logic                           err;
    logic                           rd_en;
    logic                           rd_wait;
    logic                           buf_irq;
    logic                           cmp_irq;
  } fe_state_t;
  fe_state_t s_r;
  fe_state_t s_nxt;
  logic legal;
  logic wr;
  logic launch;
  logic same_row;
  logic tick;
  logic ratio_wr;
  logic acc_set;
  function automatic logic [15:0] op_len(input logic [6:0] c);
    case (c)
      `CMD_PROGRAM:    op_len = {8'h00, `PROG_TICKS};
      `CMD_PAGE_ERASE: op_len = {8'h00, `ERASE_TICKS};
      `CMD_MASS_ERASE: op_len = {8'h00, `ERASE_TICKS};
      default:         op_len = `VERIFY_CYCLES;
    endcase
  endfunction
  assign ratio_wr = reg_sel && reg_write && (reg_addr == `OFS_CLOCK_RATIO);
  timebase_divider #(
    .RATIO_W(6)
  ) u_div (
    .clk              (clk),
    .rstn             (rstn),
    .prescale_by_eight(s_r.prescale),
    .ratio            (s_r.ratio),
    .restart          (ratio_wr),
    .tick             (tick)
  );
  always_comb begin
    s_nxt = s_r;
    wr = reg_sel && reg_write;
    legal = 1'b0;
    launch = 1'b0;
    same_row = 1'b0;
    acc_set = 1'b0;
    s_nxt.ack = 1'b0;
    s_nxt.err = 1'b0;
    s_nxt.rd_en = 1'b0;
    case (reg_wdata[6:0])
      `CMD_BLANK_CHECK, `CMD_PAGE_VERIFY, `CMD_PROGRAM,
      `CMD_PAGE_ERASE, `CMD_MASS_ERASE: legal = 1'b1; // [R2]
      default: legal = 1'b0;
    endcase
    // Array port.
    if (arr_req && !arr_write && !s_r.ack) begin // [R6]
      if (LATENCY == `LATENCY_FAST || s_r.rd_wait) begin // [R5]
        s_nxt.ack = 1'b1;
        s_nxt.rd_en = 1'b1;
        s_nxt.rd_wait = 1'b0;
      end else begin
        s_nxt.rd_wait = 1'b1;
      end
    end else if (arr_req && arr_write && !s_r.ack) begin
      s_nxt.ack = 1'b1;
      if (arr_size != 2'h2) begin
        s_nxt.err = 1'b1; // [R8]
      end else if (s_r.acc_err || !s_r.buf_empty || s_r.seq == flash_front_end_pkg::SEQ_CMD) begin
        s_nxt.acc_err = 1'b1; // [R24]
        acc_set = 1'b1;
      end else begin
        s_nxt.buf_addr = arr_addr; // [R7]
        s_nxt.buf_data = arr_wdata;
        s_nxt.seq = flash_front_end_pkg::SEQ_ARRAY;
      end
    end
    // Register writes.
    if (wr) begin
      case (reg_addr)
        `OFS_CLOCK_RATIO: begin
          s_nxt.ratio = reg_wdata[5:0];
          s_nxt.prescale = reg_wdata[`CLKD_PRESCALE_BIT];
          s_nxt.loaded = 1'b1; // [R20]
        end
        `OFS_CONTROL: begin
          s_nxt.buf_ie = reg_wdata[`CTRL_BUF_IE_BIT];
          s_nxt.cmp_ie = reg_wdata[`CTRL_CMP_IE_BIT];
        end
        `OFS_COMMAND: begin
          s_nxt.cmd = reg_wdata[6:0]; // [R1]
          if (s_r.seq == flash_front_end_pkg::SEQ_ARRAY) begin
            if (legal) begin
              s_nxt.seq = flash_front_end_pkg::SEQ_CMD;
            end else begin
              s_nxt.acc_err = 1'b1; // [R3]
              s_nxt.seq = flash_front_end_pkg::SEQ_IDLE;
            end
          end
        end
        `OFS_USER_STATUS: begin
          if (reg_wdata[`STAT_ACC_ERR_BIT] && !acc_set) begin
            s_nxt.acc_err = 1'b0;
          end
          if (reg_wdata[`STAT_BLANK_BIT]) begin
            s_nxt.blank = 1'b0;
          end
          if (reg_wdata[`STAT_BUF_EMPTY_BIT]) begin
            if (s_r.acc_err) begin
              s_nxt.acc_err = 1'b1; // [R24]
            end else if (!s_r.loaded) begin
              s_nxt.acc_err = 1'b1; // [R21] [R25]
            end else if (s_r.seq == flash_front_end_pkg::SEQ_CMD && s_r.buf_empty) begin
              launch = 1'b1; // [R22]
            end
          end else if (s_r.seq != flash_front_end_pkg::SEQ_IDLE) begin
            s_nxt.acc_err = 1'b1;
            s_nxt.seq = flash_front_end_pkg::SEQ_IDLE;
          end
        end
        default: begin
        end
      endcase
    end
    if (launch) begin
      s_nxt.pend_v = 1'b1; // [R10]
      s_nxt.pend_cmd = s_r.cmd;
      s_nxt.pend_addr = s_r.buf_addr;
      s_nxt.pend_data = s_r.buf_data;
      s_nxt.buf_empty = 1'b0;
      s_nxt.complete = 1'b0; // [R23]
      s_nxt.seq = flash_front_end_pkg::SEQ_IDLE;
    end
    // Executor.
    case (s_r.ex)
      flash_front_end_pkg::EXEC_IDLE: begin
        if (s_r.pend_v) begin
          same_row = s_r.hv && s_r.pend_cmd == `CMD_PROGRAM && s_r.ex_cmd == `CMD_PROGRAM &&
                     s_r.pend_addr[ADDR_W-1:ROW_LSB] == s_r.ex_addr[ADDR_W-1:ROW_LSB];
          s_nxt.ex_cmd = s_r.pend_cmd;
          s_nxt.ex_addr = s_r.pend_addr;
          s_nxt.ex_data = s_r.pend_data;
          s_nxt.pend_v = launch;
          s_nxt.buf_empty = !launch;
          if (same_row) begin
            s_nxt.ex = flash_front_end_pkg::EXEC_RUN; // [R11]
            s_nxt.ex_cnt = op_len(s_r.pend_cmd);
          end else begin
            s_nxt.ex = flash_front_end_pkg::EXEC_PUMP;
            s_nxt.ex_cnt = {8'h00, `PUMP_SETUP_TICKS};
            s_nxt.hv = 1'b1;
          end
        end else begin
          s_nxt.hv = 1'b0;
        end
      end
      flash_front_end_pkg::EXEC_PUMP: begin
        if (tick) begin
          if (s_r.ex_cnt == 16'h0001) begin
            s_nxt.ex = flash_front_end_pkg::EXEC_RUN;
            s_nxt.ex_cnt = op_len(s_r.ex_cmd);
          end else begin
            s_nxt.ex_cnt = s_r.ex_cnt - 16'h0001;
          end
        end
      end
      flash_front_end_pkg::EXEC_RUN: begin
        if (tick || s_r.ex_cmd == `CMD_BLANK_CHECK || s_r.ex_cmd == `CMD_PAGE_VERIFY) begin
          if (s_r.ex_cnt == 16'h0001) begin // [R19]
            s_nxt.ex = flash_front_end_pkg::EXEC_IDLE;
            if (s_r.ex_cmd == `CMD_BLANK_CHECK || s_r.ex_cmd == `CMD_PAGE_VERIFY) begin
              s_nxt.blank = s_r.blank || engine_blank;
            end
            if (!s_r.pend_v && !launch) begin
              s_nxt.complete = 1'b1;
            end
          end else begin
            s_nxt.ex_cnt = s_r.ex_cnt - 16'h0001;
          end
        end
      end
      default: s_nxt.ex = flash_front_end_pkg::EXEC_IDLE;
    endcase
    s_nxt.busy = (s_nxt.ex != flash_front_end_pkg::EXEC_IDLE);
    // Register read data.
    case (reg_addr)
      `OFS_CLOCK_RATIO:    s_nxt.rdata = {8'h00, s_r.loaded, s_r.prescale, s_r.ratio};
      `OFS_USER_STATUS:    s_nxt.rdata = {8'h00, s_r.buf_empty, s_r.complete, 1'b0,
                                          s_r.acc_err, 1'b0, s_r.blank, 2'h0};
      `OFS_COMMAND:        s_nxt.rdata = {9'h000, s_r.cmd}; // [R1]
      `OFS_LATENCY_SELECT: s_nxt.rdata = {14'h0000, LATENCY}; // [R4]
      `OFS_CONTROL:        s_nxt.rdata = {8'h00, s_r.buf_ie, s_r.cmp_ie, 6'h00};
      default:             s_nxt.rdata = 16'h0000;
    endcase
    s_nxt.buf_irq = s_nxt.buf_empty && s_nxt.buf_ie; // [R12]
    s_nxt.cmp_irq = s_nxt.complete && s_nxt.cmp_ie; // [R12]
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '0;
      s_r.buf_empty <= 1'b1;
      s_r.complete <= 1'b1;
      s_r.ex <= flash_front_end_pkg::EXEC_IDLE;
      s_r.seq <= flash_front_end_pkg::SEQ_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign reg_rdata = s_r.rdata;
  assign arr_ack = s_r.ack;
  assign arr_err = s_r.err;
  assign arr_read_en = s_r.rd_en;
  assign engine_busy = s_r.busy;
  assign engine_cmd = s_r.ex_cmd;
  assign engine_addr = s_r.ex_addr;
  assign engine_data = s_r.ex_data;
  assign high_voltage = s_r.hv;
  assign timebase_tick = tick;
  assign buf_empty_irq = s_r.buf_irq;
  assign complete_irq = s_r.cmp_irq;
endmodule
`default_nettype wire

// File: testbench/flash_front_end_properties.sv
// Port-level checks of the flash command front end.
`timescale 1ns/1ps
`default_nettype none
module flash_front_end_properties #(
  parameter logic [1:0] LATENCY = 2'b10
) (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        reg_sel,
  input wire logic        reg_write,
  input wire logic [4:0]  reg_addr,
  input wire logic [15:0] reg_rdata,
  input wire logic        arr_req,
  input wire logic        arr_write,
  input wire logic [1:0]  arr_size,
  input wire logic        arr_ack,
  input wire logic        arr_err,
  input wire logic        arr_read_en,
  input wire logic        engine_busy,
  input wire logic [6:0]  engine_cmd
);
  logic live_r;
  logic loaded_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      live_r   <= 1'b0;
      loaded_r <= 1'b0;
    end else begin
      live_r   <= 1'b1;
      loaded_r <= loaded_r | (reg_sel & reg_write & (reg_addr == 5'h02));
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_err_ack: assert property (arr_err |-> arr_ack)
    else $error("error without acknowledge");
  a_short_write: assert property (
    arr_req && arr_write && arr_size != 2'h2 && !arr_ack |=> arr_ack && arr_err)
    else $error("short write not refused");
  a_word_write: assert property (
    arr_req && arr_write && arr_size == 2'h2 && !arr_ack |=> arr_ack && !arr_err)
    else $error("word write not accepted");
  a_read_latency: assert property (
    arr_req && !arr_write && !arr_ack && !engine_busy
    |=> (LATENCY == 2'b10) ? (arr_ack && arr_read_en) : !arr_ack)
    else $error("read latency wrong");
  a_read_strobe: assert property (
    arr_read_en |-> arr_ack && !arr_err && $past(arr_req && !arr_write))
    else $error("read strobe without read");
  a_latency_fixed: assert property (
    live_r && $past(reg_addr) == 5'h07 |-> reg_rdata == {14'h0000, LATENCY})
    else $error("latency select value wrong");
  a_cmd_top_zero: assert property (
    live_r && $past(reg_addr) == 5'h06 |-> reg_rdata[15:7] == 9'h000)
    else $error("command upper bits not zero");
  a_no_exec_unloaded: assert property (!loaded_r |-> !engine_busy)
    else $error("command ran before ratio write");
  a_legal_exec: assert property (
    $rose(engine_busy) |-> engine_cmd inside {7'h05, 7'h06, 7'h20, 7'h40, 7'h41})
    else $error("illegal command executed");
  c_launch: cover property ($rose(engine_busy));
  c_short: cover property (arr_err);
  c_read: cover property (arr_read_en);
endmodule
bind flash_command_front_end flash_front_end_properties #(.LATENCY(LATENCY)) u_props (
  .clk(clk), .rstn(rstn), .reg_sel(reg_sel), .reg_write(reg_write),
  .reg_addr(reg_addr), .reg_rdata(reg_rdata), .arr_req(arr_req),
  .arr_write(arr_write), .arr_size(arr_size), .arr_ack(arr_ack), .arr_err(arr_err),
  .arr_read_en(arr_read_en), .engine_busy(engine_busy), .engine_cmd(engine_cmd));
`default_nettype wire

// File: testbench/bus_master_model.sv
// Bus master model that drives register and array transfers.
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
  input  wire logic        clk,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        arr_ack,
  input  wire logic        arr_err,
  output logic             reg_sel,
  output logic             reg_write,
  output logic [4:0]       reg_addr,
  output logic [7:0]       reg_wdata,
  output logic             arr_req,
  output logic             arr_write,
  output logic [1:0]       arr_size,
  output logic [18:0]      arr_addr,
  output logic [31:0]      arr_wdata
);
  initial begin
    {reg_sel, reg_write, reg_addr, reg_wdata} = 15'h0000;
    {arr_req, arr_write, arr_size, arr_addr, arr_wdata} = 55'h0;
  end
  task automatic reg_wr(input logic [4:0] a, input logic [7:0] d);
    {reg_sel, reg_write, reg_addr, reg_wdata} = {2'h3, a, d};
    @(posedge clk);
    #1;
    {reg_sel, reg_write, reg_wdata} = {2'h0, ~d};
    @(posedge clk);
    #1;
  endtask
  task automatic reg_rd(input logic [4:0] a, output logic [15:0] d);
    reg_addr = a;
    repeat (2) @(posedge clk);
    #1;
    d = reg_rdata;
  endtask
  task automatic launch();
    reg_wr(5'h05, 8'h80);
  endtask
  task automatic arr_xfer(input logic w, input logic [1:0] s, input logic [18:0] a,
                          input logic [31:0] d, output logic e);
    int n;
    n = 0;
    {arr_req, arr_write, arr_size, arr_addr, arr_wdata} = {1'b1, w, s, a, d};
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (arr_ack !== 1'b1 && n < 8);
    e = (arr_ack === 1'b1) ? arr_err : 1'bx;
    {arr_req, arr_addr, arr_wdata} = {1'b0, ~a, ~d};
    @(posedge clk);
    #1;
  endtask
endmodule
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench for the flash command front end.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk, rstn, engine_blank, reg_sel, reg_write, arr_req, arr_write;
  logic        arr_ack, arr_err, arr_read_en, engine_busy, high_voltage;
  logic        buf_empty_irq, complete_irq, e, on, drop;
  logic [4:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [15:0] reg_rdata, d;
  logic [1:0]  arr_size;
  logic [18:0] arr_addr, engine_addr;
  logic [31:0] arr_wdata, engine_data;
  logic [6:0]  engine_cmd;
  logic [6:0]  codes [5] = '{7'h05, 7'h06, 7'h20, 7'h40, 7'h41};
  int          errors, n_tests, n;
  flash_command_front_end i_dut (
    .clk(clk), .rstn(rstn), .reg_sel(reg_sel), .reg_write(reg_write),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .arr_req(arr_req), .arr_write(arr_write), .arr_size(arr_size), .arr_addr(arr_addr),
    .arr_wdata(arr_wdata), .arr_ack(arr_ack), .arr_err(arr_err),
    .arr_read_en(arr_read_en), .engine_busy(engine_busy), .engine_cmd(engine_cmd),
    .engine_addr(engine_addr), .engine_data(engine_data), .high_voltage(high_voltage),
    .timebase_tick(), .engine_blank(engine_blank), .buf_empty_irq(buf_empty_irq),
    .complete_irq(complete_irq));
  bus_master_model i_cpu (
    .clk(clk), .reg_rdata(reg_rdata), .arr_ack(arr_ack), .arr_err(arr_err),
    .reg_sel(reg_sel), .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .arr_req(arr_req), .arr_write(arr_write), .arr_size(arr_size), .arr_addr(arr_addr),
    .arr_wdata(arr_wdata));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic wait_busy(input logic v, input int lim);
    int k;
    k = 0;
    while (engine_busy !== v && k < lim) begin
      @(posedge clk);
      #1;
      k++;
    end
    #1;
    if (k >= lim) begin
      errors++;
      $display("[FAIL] %0t ns: busy wait timed out", $time);
      stop_test();
    end
  endtask
  task automatic seq(input logic [18:0] a, input logic [31:0] v, input logic [7:0] c);
    i_cpu.arr_xfer(1'b1, 2'h2, a, v, e);
    i_cpu.reg_wr(5'h06, c);
  endtask
  task automatic status(input logic [15:0] exp, input string s);
    i_cpu.reg_rd(5'h05, d);
    chk(d, exp);
    $display("test %0s finished", s);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {errors, n_tests, rstn, engine_blank} = {32'h0, 32'h0, 2'b01};
    repeat (6) @(posedge clk);
    #1;
    rstn = 1'b1;
    i_cpu.reg_wr(5'h07, 8'hFF);
    i_cpu.reg_rd(5'h07, d);
    chk(d, 32'h0002);
    i_cpu.reg_rd(5'h02, d);
    chk(d, 32'h0000);
    status(16'h00C0, "reset");
    seq(19'h00100, 32'h12345678, 8'h20);
    i_cpu.launch();
    status(16'h00D0, "unloaded launch");
    chk(engine_busy, 1'b0);
    i_cpu.reg_wr(5'h02, 8'h7E);
    i_cpu.reg_rd(5'h02, d);
    chk(d, 32'h00FE);
    i_cpu.launch();
    status(16'h00D0, "launch under error");
    chk(engine_busy, 1'b0);
    i_cpu.reg_wr(5'h05, 8'h10);
    i_cpu.reg_wr(5'h05, 8'h10);
    status(16'h00C0, "error cleared");
    seq(19'h00100, 32'h0, 8'hFF);
    i_cpu.reg_rd(5'h06, d);
    chk(d, 32'h007F);
    status(16'h00D0, "illegal code");
    i_cpu.reg_wr(5'h05, 8'h10);
    for (int s = 0; s < 2; s++) begin
      i_cpu.arr_xfer(1'b1, s[1:0], 19'h00200, 32'h0, e);
      chk(e, 1'b1);
    end
    i_cpu.arr_xfer(1'b0, 2'h2, 19'h00200, 32'h0, e);
    chk(e, 1'b0);
    i_cpu.arr_xfer(1'b1, 2'h2, 19'h00200, 32'h0, e);
    chk(e, 1'b0);
    i_cpu.reg_wr(5'h05, 8'h00);
    status(16'h00D0, "bus sizes and abort");
    i_cpu.reg_wr(5'h05, 8'h10);
    i_cpu.reg_wr(5'h08, 8'hC0);
    chk(buf_empty_irq, 1'b1);
    foreach (codes[i]) begin
      seq(19'h00300, 32'hA5A50000, {1'b1, codes[i]});
      i_cpu.reg_rd(5'h06, d);
      chk(d, {25'h0, codes[i]});
      i_cpu.launch();
      wait_busy(1'b1, 20);
      chk(engine_cmd, codes[i]);
      chk(complete_irq, 1'b0);
      if (codes[i] != 7'h05 && codes[i] != 7'h41) chk(engine_addr, 19'h00300);
      if (codes[i][6]) begin
        rstn = 1'b0;
        @(posedge clk);
        #1;
        rstn = 1'b1;
        chk(engine_busy, 1'b0);
        i_cpu.reg_wr(5'h02, 8'h7E);
        i_cpu.reg_wr(5'h08, 8'hC0);
        status(16'h00C0, "erase and reset");
      end else begin
        wait_busy(1'b0, 20000);
        chk(complete_irq, 1'b1);
        status(codes[i][5] ? 16'h00C0 : 16'h00C4, "command");
        i_cpu.reg_wr(5'h05, 8'h04);
      end
    end
    seq(19'h00400, 32'h11111111, 8'h20);
    i_cpu.launch();
    wait_busy(1'b1, 20);
    status(16'h0080, "first queued");
    seq(19'h00404, 32'h22222222, 8'h20);
    i_cpu.launch();
    status(16'h0000, "second queued");
    {n, on, drop} = {32'h0, 2'b00};
    while (engine_addr !== 19'h00404 && n < 20000) begin
      @(posedge clk);
      #1;
      n++;
      if (high_voltage === 1'b1) on = 1'b1;
      else if (on) drop = 1'b1;
    end
    #1;
    chk({on, drop}, 2'b10);
    chk(engine_addr, 19'h00404);
    chk(engine_data, 32'h22222222);
    wait_busy(1'b0, 20000);
    status(16'h00C0, "same row programs");
    stop_test();
  end
endmodule
`default_nettype wire
